/* File: hw/config_shadow_params.svh */
`ifndef CONFIG_SHADOW_PARAMS_SVH
`define CONFIG_SHADOW_PARAMS_SVH

// register offsets
`define OFS_CTRL_STAGE 8'h01
`define OFS_RANGE_STAGE 8'h1D
`define OFS_CTRL_ACTIVE 8'h21
`define OFS_RANGE_ACTIVE 8'h22
`define OFS_CTRL_LATCHED 8'h23
`define OFS_GPIO_DATA 8'h40

// control word fields
`define MODE_HI 15
`define MODE_LO 12
`define PIN_B_HI 11
`define PIN_B_LO 10
`define PIN_A_HI 9
`define PIN_A_LO 8
`define CHOFF_HI 7
`define CHOFF_LO 4
`define SKIP_DIS_BIT 1

// sample mode codes
`define MODE_ADAPT_1024 4'h0
`define MODE_ADAPT_8 4'h3
`define MODE_FIXED_1024 4'h4
`define MODE_FIXED_8 4'h7
`define MODE_SINGLE 4'h8
`define MODE_SINGLE_8X 4'h9
`define MODE_FAST 4'hA
`define MODE_BURST 4'hB
`define MODE_SLEEP 4'hF

// pin function codes
`define PIN_ALERT 2'h0
`define PIN_GP_IN 2'h1
`define PIN_GP_OUT 2'h2
`define PIN_SLOW 2'h3

// range codes, 2'h3 is reserved
`define FSR_UNIPOLAR 2'h0
`define FSR_BIPOLAR_FULL 2'h1
`define FSR_BIPOLAR_HALF 2'h2
`define FSR_RESERVED 2'h3

// reset values
`define CTRL_RESET_BASE 16'h0700
`define RANGE_RESET 16'h0000
`define GPIO_RESET 16'h0000

// timing
`define CLK_FREQ_MHZ 100
`define VALID_TIME_US 1000
`define VALID_CYCLES (`VALID_TIME_US * `CLK_FREQ_MHZ)

`endif

/* File: hw/config_shadow_pkg.sv */
package config_shadow_pkg;

  typedef enum logic [1:0]
  {
    st_idle = 2'b00,
    st_wait_cycle = 2'b01,
    st_settle = 2'b10
  } shadow_state_t;

endpackage

/* File: hw/config_shadow_latch_regs.sv */
`timescale 1ns/1ps
`include "config_shadow_params.svh"

module config_shadow_latch_regs
  import config_shadow_pkg::*;
#(
  parameter int unsigned CHAN_COUNT = 4,
  parameter int unsigned VALID_CYCLES = `VALID_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic refresh_req,
  input wire logic refresh_v_req,
  input wire logic refresh_g_req,
  input wire logic conv_cycle_done,
  input wire logic alert_a_req,
  input wire logic alert_b_req,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output logic alert_out_a,
  output logic alert_out_a_oe,
  output logic alert_out_b,
  output logic alert_out_b_oe,
  output logic [3:0] eff_sample_mode,
  output logic [15:0] mode_onehot,
  output logic [3:0] chan_active,
  output logic [3:0] ptr_skip_mask,
  output logic [15:0] active_range,
  output logic range_reserved,
  output logic shadow_valid,
  output logic latched_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // functions and constants

  function automatic logic [3:0] default_chan_off(input int unsigned n);
    logic [3:0] v;
    v = 4'h0;
    if (n == 3)
    begin
      v = 4'h1;
    end
    else if (n == 2)
    begin
      v = 4'h3;
    end
    else if (n == 1)
    begin
      v = 4'h7;
    end
    return v;
  endfunction

  // any two-bit range field at the reserved code
  function automatic logic has_reserved_fsr(input logic [15:0] w);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (w[2*i +: 2] == `FSR_RESERVED)
      begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  localparam logic [3:0] CHOFF_RESET = default_chan_off(CHAN_COUNT);
  localparam logic [15:0] CTRL_RESET = `CTRL_RESET_BASE | {8'h00, CHOFF_RESET, 4'h0};
  localparam logic [16:0] VALID_LAST = 17'(VALID_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] pin_a_sync_q;
  logic [1:0] pin_b_sync_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_a_sync_q <= 2'h0;
      pin_b_sync_q <= 2'h0;
    end
    else
    begin
      pin_a_sync_q <= {pin_a_sync_q[0], pin_a_in};
      pin_b_sync_q <= {pin_b_sync_q[0], pin_b_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staging registers

  logic [15:0] ctrl_stage_q;
  logic [15:0] range_stage_q;
  logic [1:0] gpio_out_q;
  logic wr_ctrl;
  logic wr_range;
  logic wr_gpio;

  assign wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL_STAGE);
  assign wr_range = reg_wr && (reg_addr == `OFS_RANGE_STAGE);
  assign wr_gpio = reg_wr && (reg_addr == `OFS_GPIO_DATA);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_stage_q <= CTRL_RESET;
      range_stage_q <= `RANGE_RESET;
      gpio_out_q <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // only the implemented bits are kept
        ctrl_stage_q <= {reg_wdata[15:4], 2'h0, reg_wdata[`SKIP_DIS_BIT], 1'b0};
      end
      if (wr_range)
      begin
        range_stage_q <= reg_wdata;
      end
      if (wr_gpio)
      begin
        gpio_out_q <= reg_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh sequencing

  shadow_state_t state_q;
  logic [15:0] ctrl_active_q;
  logic [15:0] ctrl_pending_q;
  logic [11:0] ctrl_latched_q;
  logic [15:0] range_active_q;
  logic [16:0] settle_cnt_q;
  logic shadow_valid_q;
  logic latched_valid_q;
  logic any_refresh;
  logic rate_change;

  // all three refresh flavours treated alike for the shadows
  assign any_refresh = refresh_req || refresh_v_req || refresh_g_req;
  assign rate_change = ctrl_stage_q[`MODE_HI:`MODE_LO] != ctrl_active_q[`MODE_HI:`MODE_LO];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= st_idle;
      ctrl_active_q <= CTRL_RESET;
      ctrl_pending_q <= CTRL_RESET;
      range_active_q <= `RANGE_RESET;
    end
    else if (any_refresh)
    begin
      ctrl_pending_q <= ctrl_stage_q;
      range_active_q <= range_stage_q;
      if (rate_change)
      begin
        // the new rate waits for the running conversion to finish
        state_q <= st_wait_cycle;
      end
      else
      begin
        ctrl_active_q <= ctrl_stage_q;
        state_q <= st_settle;
      end
    end
    else
    begin
      case (state_q)
        st_wait_cycle:
        begin
          if (conv_cycle_done)
          begin
            ctrl_active_q <= ctrl_pending_q;
            state_q <= st_settle;
          end
        end
        st_settle:
        begin
          if (settle_cnt_q == VALID_LAST)
          begin
            state_q <= st_idle;
          end
        end
        default:
        begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // latched image is the control word in force just before the command
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_latched_q <= CTRL_RESET[15:4];
      latched_valid_q <= 1'b0;
    end
    else if (any_refresh)
    begin
      ctrl_latched_q <= ctrl_active_q[15:4];
      latched_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      settle_cnt_q <= 17'h00000;
      shadow_valid_q <= 1'b0;
    end
    else if (any_refresh)
    begin
      settle_cnt_q <= 17'h00000;
      shadow_valid_q <= 1'b0;
    end
    else if (state_q == st_settle)
    begin
      settle_cnt_q <= settle_cnt_q + 17'h00001;
      if (settle_cnt_q == VALID_LAST)
      begin
        shadow_valid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `OFS_CTRL_STAGE: reg_rdata <= ctrl_stage_q;
        `OFS_RANGE_STAGE: reg_rdata <= range_stage_q;
        `OFS_CTRL_ACTIVE: reg_rdata <= ctrl_active_q;
        `OFS_RANGE_ACTIVE: reg_rdata <= range_active_q;
        `OFS_CTRL_LATCHED: reg_rdata <= {ctrl_latched_q, 4'h0};
        `OFS_GPIO_DATA: reg_rdata <= {12'h000, pin_b_sync_q[1], pin_a_sync_q[1], gpio_out_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived block outputs

  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic slow_force;
  logic [3:0] mode_d;

  assign sel_a = ctrl_active_q[`PIN_A_HI:`PIN_A_LO];
  assign sel_b = ctrl_active_q[`PIN_B_HI:`PIN_B_LO];
  assign slow_force = (sel_a == `PIN_SLOW && pin_a_sync_q[1]) || (sel_b == `PIN_SLOW && pin_b_sync_q[1]);
  // sleep is never overridden by the slow pin: there is no conversion to slow down
  assign mode_d = (slow_force && ctrl_active_q[`MODE_HI:`MODE_LO] != `MODE_SLEEP) ? `MODE_FIXED_8 :
                  ctrl_active_q[`MODE_HI:`MODE_LO];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      eff_sample_mode <= `MODE_ADAPT_1024;
      mode_onehot <= 16'h0001;
      chan_active <= 4'hF;
      ptr_skip_mask <= 4'h0;
      active_range <= `RANGE_RESET;
      range_reserved <= 1'b0;
      shadow_valid <= 1'b0;
      latched_valid <= 1'b0;
    end
    else
    begin
      eff_sample_mode <= mode_d;
      mode_onehot <= 16'h0001 << mode_d;
      chan_active <= ~ctrl_active_q[`CHOFF_HI:`CHOFF_LO];
      ptr_skip_mask <= ctrl_active_q[`SKIP_DIS_BIT] ? 4'h0 : ctrl_active_q[`CHOFF_HI:`CHOFF_LO];
      active_range <= range_active_q;
      range_reserved <= has_reserved_fsr(range_active_q);
      shadow_valid <= shadow_valid_q;
      latched_valid <= latched_valid_q && shadow_valid_q;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      alert_out_a <= 1'b0;
      alert_out_a_oe <= 1'b0;
      alert_out_b <= 1'b0;
      alert_out_b_oe <= 1'b0;
    end
    else
    begin
      alert_out_a <= (sel_a == `PIN_ALERT) ? alert_a_req : gpio_out_q[0];
      alert_out_a_oe <= (sel_a == `PIN_ALERT) || (sel_a == `PIN_GP_OUT);
      alert_out_b <= (sel_b == `PIN_ALERT) ? alert_b_req : gpio_out_q[1];
      alert_out_b_oe <= (sel_b == `PIN_ALERT) || (sel_b == `PIN_GP_OUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence refresh_same_rate;
    any_refresh && !rate_change;
  endsequence

  sequence refresh_new_rate;
    any_refresh && rate_change;
  endsequence

  a_latch_capture: assert property (@(posedge clock) disable iff (!nrst)
    any_refresh |=> ctrl_latched_q == $past(ctrl_active_q[15:4]))
    else $error("latched image did not take the prior active control");

  a_stage_promote: assert property (@(posedge clock) disable iff (!nrst)
    refresh_same_rate |=> ctrl_active_q == $past(ctrl_stage_q))
    else $error("staged control not promoted on refresh");

  a_rate_deferred: assert property (@(posedge clock) disable iff (!nrst)
    refresh_new_rate |=> state_q == st_wait_cycle && $stable(ctrl_active_q))
    else $error("rate change applied before conversion cycle end");

  a_valid_clear: assert property (@(posedge clock) disable iff (!nrst)
    any_refresh |-> ##2 !shadow_valid)
    else $error("shadow valid not dropped after refresh");

  a_settle_count: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == st_settle && settle_cnt_q == VALID_LAST && !any_refresh) |=> shadow_valid_q)
    else $error("shadow valid not raised at end of settle time");

  a_latched_invalid: assert property (@(posedge clock) disable iff (!nrst)
    !latched_valid_q |-> !latched_valid)
    else $error("latched image flagged valid before first refresh");

  a_latched_low_zero: assert property (@(posedge clock) disable iff (!nrst)
    (reg_rd && reg_addr == `OFS_CTRL_LATCHED) |=> reg_rdata[3:0] == 4'h0)
    else $error("latched control low bits not zero");

  a_latched_no_write: assert property (@(posedge clock) disable iff (!nrst)
    (reg_wr && !any_refresh) |=> $stable(ctrl_latched_q))
    else $error("latched control changed without refresh");

  a_mode_onehot: assert property (@(posedge clock) disable iff (!nrst)
    $onehot(mode_onehot))
    else $error("sample mode not exactly one");

  a_slow_override: assert property (@(posedge clock) disable iff (!nrst)
    (slow_force && ctrl_active_q[`MODE_HI:`MODE_LO] != `MODE_SLEEP) |=> eff_sample_mode == `MODE_FIXED_8)
    else $error("slow pin did not force 8 SPS");

  a_skip_mask: assert property (@(posedge clock) disable iff (!nrst)
    ctrl_active_q[`SKIP_DIS_BIT] |=> ptr_skip_mask == 4'h0)
    else $error("pointer skipping not disabled");

endmodule

/* File: verif/host_model.sv */
`timescale 1ns/1ps
// host side of the register port: one strobe per cycle, changed just after a rising edge
module host_model
(
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // released data is scrambled so nothing relies on a stale word
    reg_wdata <= ~d;
  endtask

  // data stand only in the cycle after the read edge, so sample just after it
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "config_shadow_params.svh"
module testbench
  import config_shadow_pkg::*;
;
  logic clock, nrst, refresh_req, refresh_v_req, refresh_g_req, conv_cycle_done;
  logic alert_a_req, alert_b_req, pin_a_in, pin_b_in;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mode_onehot, active_range, rv;
  logic reg_wr, reg_rd, alert_out_a, alert_out_a_oe, alert_out_b, alert_out_b_oe;
  logic [3:0] eff_sample_mode, chan_active, ptr_skip_mask;
  logic range_reserved, shadow_valid, latched_valid;
  int mismatches = 0;
  int n_checks = 0;

  config_shadow_latch_regs #(.CHAN_COUNT(4), .VALID_CYCLES(16)) dut_u (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .refresh_req(refresh_req), .refresh_v_req(refresh_v_req), .refresh_g_req(refresh_g_req),
    .conv_cycle_done(conv_cycle_done), .alert_a_req(alert_a_req), .alert_b_req(alert_b_req),
    .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .alert_out_a(alert_out_a), .alert_out_a_oe(alert_out_a_oe),
    .alert_out_b(alert_out_b), .alert_out_b_oe(alert_out_b_oe), .eff_sample_mode(eff_sample_mode),
    .mode_onehot(mode_onehot), .chan_active(chan_active), .ptr_skip_mask(ptr_skip_mask),
    .active_range(active_range), .range_reserved(range_reserved), .shadow_valid(shadow_valid),
    .latched_valid(latched_valid));

  host_model host_u (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // command pulses, one cycle long; kind 0 full, 1 voltage-only, 2 general call
  task automatic refresh(input int kind);
    @(posedge clock);
    refresh_req <= (kind == 0);
    refresh_v_req <= (kind == 1);
    refresh_g_req <= (kind == 2);
    @(posedge clock);
    refresh_req <= 1'b0;
    refresh_v_req <= 1'b0;
    refresh_g_req <= 1'b0;
  endtask

  task automatic conv_done();
    @(posedge clock);
    conv_cycle_done <= 1'b1;
    @(posedge clock);
    conv_cycle_done <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    host_u.rd(8'h23, rv);
    check("latched reset", 16'h0700, rv);
    host_u.rd(8'h22, rv);
    check("range reset", 16'h0000, rv);
    check("chan_active", 16'h000F, {12'h000, chan_active});
    check("onehot reset", 16'h0001, mode_onehot);
    check("latched_valid", 16'h0000, {15'h0, latched_valid});
    host_u.rd(8'h7F, rv);
    check("unmapped", 16'h0000, rv);
  endtask

  // staged word is invisible until refresh, then becomes active and old active is latched
  task automatic t_stage();
    host_u.wr(8'h01, 16'h0E9F);
    host_u.rd(8'h21, rv);
    check("active before", 16'h0700, rv);
    refresh(0);
    settle(3);
    host_u.rd(8'h21, rv);
    check("active after", 16'h0E92, rv);
    host_u.rd(8'h23, rv);
    check("latched prior", 16'h0700, rv);
    check("chan_active", 16'h0006, {12'h000, chan_active});
    check("skip off", 16'h0000, {12'h000, ptr_skip_mask});
    host_u.wr(8'h23, 16'hFFFF);
    host_u.rd(8'h23, rv);
    check("latched ro", 16'h0700, rv);
    host_u.wr(8'h01, 16'h0D50);
    refresh(0);
    settle(3);
    check("skip mask", 16'h0005, {12'h000, ptr_skip_mask});
    host_u.rd(8'h23, rv);
    check("latched low zero", 16'h0E90, rv);
  endtask

  task automatic t_range();
    int k;
    host_u.wr(8'h1D, 16'h1B27);
    refresh(1);
    settle(3);
    check("shadow low", 16'h0000, {15'h0, shadow_valid});
    host_u.rd(8'h22, rv);
    check("range read", 16'h1B27, rv);
    check("range port", 16'h1B27, active_range);
    check("range rsvd", 16'h0001, {15'h0, range_reserved});
    for (k = 0; k < 40 && shadow_valid !== 1'b1; k++)
      settle(1);
    if (k == 40)
    begin
      mismatches++;
      tally_and_finish();
    end
    else
    begin
      check("latched valid", 16'h0001, {15'h0, latched_valid});
    end
  endtask

  // pin functions: gp output drives the data bit, alert drives, slow high forces 8 SPS
  task automatic t_pins();
    host_u.wr(8'h01, 16'h0200);
    refresh(2);
    host_u.wr(8'h40, 16'h0001);
    settle(3);
    check("pin a out", 16'h0003, {14'h0, alert_out_a, alert_out_a_oe});
    check("pin b alert", 16'h0003, {14'h0, alert_out_b, alert_out_b_oe});
    // both pins as alert; gp data low so the alert level must come from the request
    host_u.wr(8'h01, 16'h0000);
    host_u.wr(8'h40, 16'h0000);
    refresh(1);
    alert_a_req <= 1'b1;
    settle(3);
    check("pin a alert", 16'h0003, {14'h0, alert_out_a, alert_out_a_oe});
    host_u.wr(8'h01, 16'h0700);
    refresh(0);
    pin_a_in <= 1'b1;
    pin_b_in <= 1'b1;
    settle(6);
    check("slow force", 16'h0007, {12'h000, eff_sample_mode});
    check("oe off", 16'h0000, {14'h0, alert_out_a_oe, alert_out_b_oe});
    host_u.rd(8'h40, rv);
    check("gp in b", 16'h0008, rv & 16'h0008);
    @(posedge clock);
    pin_a_in <= 1'b0;
  endtask

  // every mode code; a change waits for the end of the conversion cycle
  task automatic t_modes();
    logic [3:0] c, p;
    p = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i + 1);
      host_u.wr(8'h01, {c, 12'h500});
      refresh(i % 3);
      settle(3);
      host_u.rd(8'h21, rv);
      check("held rate", {12'h000, p}, {12'h000, rv[15:12]});
      host_u.rd(8'h23, rv);
      check("latched", (i == 0) ? 16'h0700 : {p, 12'h500}, rv);
      conv_done();
      settle(3);
      host_u.rd(8'h21, rv);
      check("new rate", {c, 12'h500}, rv);
      check("mode", {12'h000, c}, {12'h000, eff_sample_mode});
      check("onehot", 16'h0001 << c, mode_onehot);
      p = c;
    end
  endtask

  initial
  begin
    nrst = 1'b0;
    {refresh_req, refresh_v_req, refresh_g_req, conv_cycle_done} = 4'h0;
    {alert_a_req, alert_b_req, pin_a_in, pin_b_in} = 4'h0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    alert_b_req <= 1'b1;
    settle(2);
    t_reset();
    t_stage();
    t_range();
    t_pins();
    t_modes();
    tally_and_finish();
  end
endmodule
